//--- lsc_regs.sv
// Register slice for string faults, ramp timing, brightness setup and string enables.
`timescale 1ns/1ns

// How it works
// - An open on any enabled string sets the open flag in bit 1 of the fault status.
// - The open flag holds until status is read and the enable of each open string is cleared.
// - A short on any string sets the short flag in bit 0 of the fault status.
// - The short flag holds until status is read and all six string enables are cleared.
// - Fault status bits 7:2 always read zero, and the flags read zero with no fault.
// - The ramp period value times 50 us is the time between brightness steps.
// - A ramp period of zero turns fading off, so brightness jumps straight to its target.
// - Bit 7 of the brightness setup picks linear (0, reset) or logarithmic (1) profile.
// - Bit 6 of the brightness setup picks analog only (0) or hybrid PWM (1, reset) dimming.
// - Bits 5:4 place the hybrid crossover at 12.5, 25 (reset), 50 or 100 percent.
// - Bits 3:2 pick the brightness source: PWM duty, code, both, or direct PWM.
// - Bits 1:0 pick full-scale current of 15, 20, 25 or 30 mA, with 30 mA at reset.
// - Bit 7 of the enable register picks the internal field or external resistor for full scale.
// - Bits 5:0 of the enable register turn each string sink on, all off after reset.
// - A low brightness code write only takes effect on the next write to another register.
module lsc_regs #(
	parameter int STEP_CYCLES = lsc_pkg::LSC_STEP_CYCLES
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic [5:0] open_det_pin,
	input wire logic [5:0] short_det_pin,
	input wire logic pwm_in,
	output logic pwm_level,
	output logic string_open_flag,
	output logic string_short_flag,
	output logic log_profile,
	output logic dimming_style,
	output logic [1:0] hybrid_crossover,
	output logic [1:0] brightness_source,
	output logic [1:0] fullscale_code,
	output logic external_fullscale_select,
	output logic [5:0] string_enable,
	output logic [11:0] brightness_code,
	output logic [11:0] brightness_applied
);
	import lsc_pkg::*;

	// Every register and synchroniser stage of the slice.
	typedef struct packed {
		logic [5:0] open_s1;
		logic [5:0] open_s2;
		logic [5:0] short_s1;
		logic [5:0] short_s2;
		logic pwm_s1;
		logic pwm_s2;
		logic pwm_out;
		logic [7:0] ramp_period;
		logic [7:0] bright_cfg;
		logic [7:0] string_en;
		logic [3:0] code_low_pend;
		logic [3:0] code_low_live;
		logic [7:0] code_high;
		logic low_pending;
		logic [7:0] rdata;
		logic [11:0] code_out;
	} lsc_regs_state_t;

	lsc_regs_state_t cur_reg;
	lsc_regs_state_t cur_next;

	logic status_read;
	logic flag_open;
	logic flag_short;
	logic [11:0] ramp_target;
	logic [11:0] ramp_applied;

	// Decodes a write hit on one register offset.
	function automatic logic wr_hit(input logic wr, input logic [7:0] addr,
			input logic [7:0] off);
		wr_hit = wr && (addr == off);
	endfunction

	// Builds the fault status byte; the upper six bits are reserved and read zero.
	function automatic logic [7:0] fault_byte(input logic open_f, input logic short_f);
		logic [7:0] b;
		b = 8'h00;
		b[LSC_FS_OPEN_BIT] = open_f;
		b[LSC_FS_SHORT_BIT] = short_f;
		fault_byte = b;
	endfunction

	// Read multiplexer; an unmapped offset answers with a fixed zero byte.
	function automatic logic [7:0] read_mux(input logic [7:0] addr, input lsc_regs_state_t s,
			input logic open_f, input logic short_f);
		logic [7:0] d;
		d = LSC_RD_UNMAPPED;
		case (addr)
			LSC_OFF_FAULT_STATUS: d = fault_byte(open_f, short_f);
			LSC_OFF_RAMP_PERIOD: d = s.ramp_period;
			LSC_OFF_BRIGHT_CFG: d = s.bright_cfg;
			LSC_OFF_STRING_EN: d = s.string_en;
			LSC_OFF_CODE_LOW: d = {s.code_low_pend, 4'h0};
			LSC_OFF_CODE_HIGH: d = s.code_high;
			default: d = LSC_RD_UNMAPPED;
		endcase
		read_mux = d;
	endfunction

	// A status read is what arms the sticky flags for clearing.
	assign status_read = reg_rd && (reg_addr == LSC_OFF_FAULT_STATUS);

	// The ramp chases the code that has actually been committed, never a half-written one.
	assign ramp_target = {cur_reg.code_high, cur_reg.code_low_live};

	// Next-state logic for synchronisers, register writes and read data.
	always_comb begin
		cur_next = cur_reg;

		// Fault detectors and PWM arrive from analog blocks, so each passes two sync flops; PWM then passes a third, output flop.
		cur_next.open_s1 = open_det_pin;
		cur_next.open_s2 = cur_reg.open_s1;
		cur_next.short_s1 = short_det_pin;
		cur_next.short_s2 = cur_reg.short_s1;
		cur_next.pwm_s1 = pwm_in;
		cur_next.pwm_s2 = cur_reg.pwm_s1;
		cur_next.pwm_out = cur_reg.pwm_s2;

		// Ramp step period, a plain 8-bit field.
		if (wr_hit(reg_wr, reg_addr, LSC_OFF_RAMP_PERIOD)) begin
			cur_next.ramp_period = reg_wdata;
		end

		// Brightness setup: profile, style, crossover, source and full scale in one byte.
		if (wr_hit(reg_wr, reg_addr, LSC_OFF_BRIGHT_CFG)) begin
			cur_next.bright_cfg = reg_wdata;
		end

		// Enables, the external full-scale select and a reserved read/write bit.
		if (wr_hit(reg_wr, reg_addr, LSC_OFF_STRING_EN)) begin
			cur_next.string_en = reg_wdata;
		end

		// Low code bits are staged; any later write to another offset commits them.
		// Writing the low part twice in a row simply replaces the staged value.
		if (wr_hit(reg_wr, reg_addr, LSC_OFF_CODE_LOW)) begin
			cur_next.code_low_pend = reg_wdata[LSC_CODE_LOW_LSB +: 4];
			cur_next.low_pending = 1'b1;
		end else if (reg_wr && cur_reg.low_pending) begin
			cur_next.code_low_live = cur_reg.code_low_pend;
			cur_next.low_pending = 1'b0;
		end

		// High code bits take effect at once, together with any staged low bits.
		if (wr_hit(reg_wr, reg_addr, LSC_OFF_CODE_HIGH)) begin
			cur_next.code_high = reg_wdata;
		end

		// Registered code output is built from the next committed pair, so it changes on the same edge.
		cur_next.code_out = {cur_next.code_high, cur_next.code_low_live};

		// Read data is registered and holds until the next read.
		if (reg_rd) begin
			cur_next.rdata = read_mux(reg_addr, cur_reg, flag_open, flag_short);
		end
	end

	// Single state register for the slice.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			cur_reg <= '0;
			cur_reg.ramp_period <= LSC_RST_RAMP_PERIOD;
			cur_reg.bright_cfg <= LSC_RST_BRIGHT_CFG;
			cur_reg.string_en <= LSC_RST_STRING_EN;
			cur_reg.code_low_pend <= LSC_RST_CODE_LOW[LSC_CODE_LOW_LSB +: 4];
			cur_reg.code_low_live <= LSC_RST_CODE_LOW[LSC_CODE_LOW_LSB +: 4];
			cur_reg.code_high <= LSC_RST_CODE_HIGH;
		end else begin
			cur_reg <= cur_next;
		end
	end

	// Sticky fault flags; opens only count on enabled strings.
	lsc_fault_flags u_flags (
		.ref_clk(ref_clk),
		.rst(rst),
		.open_det(cur_reg.open_s2),
		.short_det(cur_reg.short_s2),
		.string_enable(cur_reg.string_en[LSC_EN_STRINGS-1:0]),
		.status_read(status_read),
		.string_open_flag(flag_open),
		.string_short_flag(flag_short)
	);

	// Brightness ramp stepping at the programmed period.
	lsc_ramp #(
		.STEP_CYCLES(STEP_CYCLES)
	) u_ramp (
		.ref_clk(ref_clk),
		.rst(rst),
		.step_period(cur_reg.ramp_period),
		.target_code(ramp_target),
		.applied_code(ramp_applied)
	);

	// Outputs; each is a flop of this module or of a submodule.
	assign reg_rdata = cur_reg.rdata;
	assign pwm_level = cur_reg.pwm_out;
	assign string_open_flag = flag_open;
	assign string_short_flag = flag_short;
	assign log_profile = cur_reg.bright_cfg[LSC_CFG_PROFILE_BIT];
	assign dimming_style = cur_reg.bright_cfg[LSC_CFG_STYLE_BIT];
	assign hybrid_crossover = cur_reg.bright_cfg[LSC_CFG_XOVER_LSB +: 2];
	assign brightness_source = cur_reg.bright_cfg[LSC_CFG_SOURCE_LSB +: 2];
	assign fullscale_code = cur_reg.bright_cfg[LSC_CFG_FSCALE_LSB +: 2];
	assign external_fullscale_select = cur_reg.string_en[LSC_EN_EXTSEL_BIT];
	assign string_enable = cur_reg.string_en[LSC_EN_STRINGS-1:0];
	assign brightness_code = cur_reg.code_out;
	assign brightness_applied = ramp_applied;
endmodule

//--- lsc_pkg.sv
// Shared offsets, field positions, reset values and timing for the LED string register slice.
package lsc_pkg;

	// Register offsets on the serial register port.
	localparam logic [7:0] LSC_OFF_FAULT_STATUS = 8'h03;
	localparam logic [7:0] LSC_OFF_RAMP_PERIOD = 8'h04;
	localparam logic [7:0] LSC_OFF_BRIGHT_CFG = 8'h05;
	localparam logic [7:0] LSC_OFF_STRING_EN = 8'h06;
	localparam logic [7:0] LSC_OFF_CODE_LOW = 8'h07;
	localparam logic [7:0] LSC_OFF_CODE_HIGH = 8'h08;

	// Reset values.
	localparam logic [7:0] LSC_RST_RAMP_PERIOD = 8'h00;
	localparam logic [7:0] LSC_RST_BRIGHT_CFG = 8'h53;
	localparam logic [7:0] LSC_RST_STRING_EN = 8'h00;
	localparam logic [7:0] LSC_RST_CODE_LOW = 8'h00;
	localparam logic [7:0] LSC_RST_CODE_HIGH = 8'h00;
	localparam logic [7:0] LSC_RD_UNMAPPED = 8'h00;

	// Fault status field positions.
	localparam int LSC_FS_SHORT_BIT = 0;
	localparam int LSC_FS_OPEN_BIT = 1;

	// Brightness configuration field positions.
	localparam int LSC_CFG_PROFILE_BIT = 7;
	localparam int LSC_CFG_STYLE_BIT = 6;
	localparam int LSC_CFG_XOVER_LSB = 4;
	localparam int LSC_CFG_SOURCE_LSB = 2;
	localparam int LSC_CFG_FSCALE_LSB = 0;

	// String enable field positions.
	localparam int LSC_EN_EXTSEL_BIT = 7;
	localparam int LSC_EN_STRINGS = 6;

	// Low brightness code part lives in bits 7:4 of its register.
	localparam int LSC_CODE_LOW_LSB = 4;

	// Ramp step time: 50 us per unit of the period field at a 125 MHz clock.
	localparam int LSC_STEP_TIME_US = 50;
	localparam int LSC_CLK_KHZ = 125000;
	localparam int LSC_STEP_CYCLES = (LSC_STEP_TIME_US * LSC_CLK_KHZ) / 1000;

endpackage

//--- lsc_fault_flags.sv
// Sticky open and short string fault flags with their read-then-disable clearing.
`timescale 1ns/1ns
module lsc_fault_flags (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [5:0] open_det,
	input wire logic [5:0] short_det,
	input wire logic [5:0] string_enable,
	input wire logic status_read,
	output logic string_open_flag,
	output logic string_short_flag
);
	import lsc_pkg::*;

	typedef struct packed {
		logic open_flag;
		logic short_flag;
		logic [5:0] open_src;
		logic open_armed;
		logic short_armed;
	} lsc_flag_state_t;

	lsc_flag_state_t cur_reg;
	lsc_flag_state_t cur_next;

	logic [5:0] open_hit;
	logic open_clear;
	logic short_clear;

	// Clearing needs a status read and the disable, in either order; a read in the clearing cycle counts.
	always_comb begin
		cur_next = cur_reg;
		open_hit = open_det & string_enable;
		open_clear = cur_reg.open_flag && (cur_reg.open_armed || status_read) &&
			((cur_reg.open_src & string_enable) == 6'h00);
		short_clear = cur_reg.short_flag && (cur_reg.short_armed || status_read) &&
			(string_enable == 6'h00);
		if (status_read && cur_reg.open_flag) begin
			cur_next.open_armed = 1'b1;
		end
		if (status_read && cur_reg.short_flag) begin
			cur_next.short_armed = 1'b1;
		end
		if (open_clear) begin
			cur_next.open_flag = 1'b0;
			cur_next.open_src = 6'h00;
			cur_next.open_armed = 1'b0;
		end
		if (short_clear) begin
			cur_next.short_flag = 1'b0;
			cur_next.short_armed = 1'b0;
		end
		// A detection in the clearing cycle sets the flag again, so no event is lost.
		if (|open_hit) begin
			cur_next.open_flag = 1'b1;
			cur_next.open_src = cur_next.open_src | open_hit;
		end
		if (|short_det) begin
			cur_next.short_flag = 1'b1;
		end
	end

	// State register.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			cur_reg <= '0;
		end else begin
			cur_reg <= cur_next;
		end
	end

	assign string_open_flag = cur_reg.open_flag;
	assign string_short_flag = cur_reg.short_flag;
endmodule

//--- lsc_ramp.sv
// Brightness ramp: steps the applied code toward the target once per ramp step period.
`timescale 1ns/1ns
module lsc_ramp #(
	parameter int STEP_CYCLES = lsc_pkg::LSC_STEP_CYCLES
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [7:0] step_period,
	input wire logic [11:0] target_code,
	output logic [11:0] applied_code
);
	import lsc_pkg::*;

	typedef struct packed {
		logic [15:0] div_cnt;
		logic [7:0] tick_cnt;
		logic [11:0] applied;
	} lsc_ramp_state_t;

	lsc_ramp_state_t cur_reg;
	lsc_ramp_state_t cur_next;

	logic unit_tick;

	// The divider makes one pulse per 50 us unit; the period field counts those pulses.
	always_comb begin
		cur_next = cur_reg;
		unit_tick = 1'b0;
		if (step_period == 8'h00) begin
			cur_next.div_cnt = 16'h0000;
			cur_next.tick_cnt = 8'h00;
			cur_next.applied = target_code;
		end else begin
			if (cur_reg.div_cnt >= 16'(STEP_CYCLES - 1)) begin
				cur_next.div_cnt = 16'h0000;
				unit_tick = 1'b1;
			end else begin
				cur_next.div_cnt = cur_reg.div_cnt + 16'h0001;
			end
			if (unit_tick) begin
				if (cur_reg.tick_cnt + 8'h01 >= step_period) begin
					cur_next.tick_cnt = 8'h00;
					if (cur_reg.applied < target_code) begin
						cur_next.applied = cur_reg.applied + 12'h001;
					end else if (cur_reg.applied > target_code) begin
						cur_next.applied = cur_reg.applied - 12'h001;
					end
				end else begin
					cur_next.tick_cnt = cur_reg.tick_cnt + 8'h01;
				end
			end
		end
	end

	// State register.
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			cur_reg <= '0;
		end else begin
			cur_reg <= cur_next;
		end
	end

	assign applied_code = cur_reg.applied;
endmodule

//--- lsc_regs_asserts.sv
// Concurrent checks on the ports of the LED string register slice.
`timescale 1ns/1ns
module lsc_regs_chk (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic [5:0] open_det_pin,
	input wire logic [5:0] short_det_pin,
	input wire logic string_open_flag,
	input wire logic string_short_flag,
	input wire logic log_profile,
	input wire logic dimming_style,
	input wire logic [1:0] hybrid_crossover,
	input wire logic [1:0] brightness_source,
	input wire logic [1:0] fullscale_code,
	input wire logic [5:0] string_enable
);
	import lsc_pkg::*;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	// Status reads return both flags as they stood when the read was taken.
	stat_read_a: assert property (reg_rd && reg_addr == 8'h03 |=>
		reg_rdata == {6'h00, $past(string_open_flag), $past(string_short_flag)})
		else $error("status read value wrong");
	// Detector delay is two sync flops plus the flag flop.
	open_set_a: assert property ((|(open_det_pin & string_enable))[*3] |=> string_open_flag)
		else $error("open flag not set");
	short_set_a: assert property ((|short_det_pin)[*3] |=> string_short_flag)
		else $error("short flag not set");
	short_hold_a: assert property (string_short_flag && string_enable != 6'h00 |=>
		string_short_flag) else $error("short flag cleared with strings enabled");
	short_fall_a: assert property ($fell(string_short_flag) |-> $past(string_enable) == 6'h00)
		else $error("short flag fell without all enables low");
	// Each sampled history is taken per signal, so the check reads the same on every tool.
	cfg_write_a: assert property (reg_wr && reg_addr == 8'h05 |=>
		{log_profile, dimming_style, 6'h00} == ($past(reg_wdata) & 8'hC0))
		else $error("profile or style not taken from write");
	cfg_read_a: assert property (reg_rd && reg_addr == 8'h05 |=> reg_rdata ==
		{$past(log_profile), $past(dimming_style), $past(hybrid_crossover),
		$past(brightness_source), $past(fullscale_code)})
		else $error("config readback wrong");
	en_write_a: assert property (reg_wr && reg_addr == 8'h06 |=>
		{2'h0, string_enable} == ($past(reg_wdata) & 8'h3F))
		else $error("string enables not written");
endmodule
bind lsc_regs lsc_regs_chk i_lsc_regs_chk (.ref_clk, .rst, .reg_addr, .reg_wr, .reg_wdata,
	.reg_rd, .reg_rdata, .open_det_pin, .short_det_pin, .string_open_flag, .string_short_flag,
	.log_profile, .dimming_style, .hybrid_crossover, .brightness_source, .fullscale_code,
	.string_enable);

//--- lsc_host.sv
// Host model that drives the register port with single-cycle strobes.
`timescale 1ns/1ns
module lsc_host (
	input wire logic ref_clk,
	output logic [7:0] reg_addr,
	output logic reg_wr,
	output logic [7:0] reg_wdata,
	output logic reg_rd,
	input wire logic [7:0] reg_rdata
);
	initial begin
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end
	// Idle address and data are inverted so the slice cannot lean on stale bus values.
	task automatic idle();
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = ~reg_addr;
		reg_wdata = ~reg_wdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		#1;
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(posedge ref_clk);
		#1;
		idle();
	endtask
	// Read data is registered at the taking edge, so it is settled just after it.
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge ref_clk);
		#1;
		reg_addr = a;
		reg_rd = 1'b1;
		@(posedge ref_clk);
		#1;
		idle();
		d = reg_rdata;
	endtask
endmodule

//--- tb.sv
// Self-checking testbench for the LED string register slice.
`timescale 1ns/1ns
module tb;
	import lsc_pkg::*;
	localparam int STEPS = 4;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic [5:0] open_det_pin = 6'h00;
	logic [5:0] short_det_pin = 6'h00;
	logic pwm_in = 1'b0;
	logic [7:0] reg_addr, reg_wdata, reg_rdata;
	logic reg_wr, reg_rd, pwm_level, string_open_flag, string_short_flag, log_profile;
	logic dimming_style, external_fullscale_select;
	logic [1:0] hybrid_crossover, brightness_source, fullscale_code;
	logic [5:0] string_enable;
	logic [11:0] brightness_code, brightness_applied;
	int failures = 0;
	int checks = 0;
	always #4 ref_clk = ~ref_clk;
	lsc_host host (.ref_clk, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata);
	lsc_regs #(.STEP_CYCLES(STEPS)) i_lsc_regs (.ref_clk, .rst, .reg_addr, .reg_wr,
		.reg_wdata, .reg_rd, .reg_rdata, .open_det_pin, .short_det_pin, .pwm_in, .pwm_level,
		.string_open_flag, .string_short_flag, .log_profile, .dimming_style, .hybrid_crossover,
		.brightness_source, .fullscale_code, .external_fullscale_select, .string_enable,
		.brightness_code, .brightness_applied);
	task automatic chk(input logic [11:0] got, input logic [11:0] exp, input string what);
		checks++;
		if (got !== exp) begin
			failures++;
			$display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	task automatic rchk(input logic [7:0] a, input logic [7:0] exp, input string what);
		logic [7:0] d;
		host.rd(a, d);
		chk({4'h0, d}, {4'h0, exp}, what);
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	task automatic test_reset();
		rchk(8'h03, 8'h00, "status reset");
		rchk(8'h04, 8'h00, "ramp reset");
		rchk(8'h05, 8'h53, "config reset");
		rchk(8'h06, 8'h00, "enable reset");
		chk({4'h0, log_profile, dimming_style, hybrid_crossover, brightness_source,
			fullscale_code}, 12'h053, "config outputs reset");
		chk(brightness_code, 12'h000, "code reset");
		chk(brightness_applied, 12'h000, "applied reset");
		$display("test reset done");
	endtask
	// Every code of the three two-bit fields, with profile and style toggled too.
	task automatic test_cfg();
		logic [7:0] v;
		for (int i = 0; i < 4; i++) begin
			v = {i[0], ~i[0], i[1:0], i[1:0], i[1:0]};
			host.wr(8'h05, v);
			chk({4'h0, log_profile, dimming_style, hybrid_crossover, brightness_source,
				fullscale_code}, {4'h0, v}, "config fields");
			rchk(8'h05, v, "config readback");
		end
		host.wr(8'h06, 8'hBF);
		chk({5'h00, external_fullscale_select, string_enable}, 12'h07F, "enables");
		rchk(8'h06, 8'hBF, "enable readback");
		host.wr(8'h03, 8'hFF);
		rchk(8'h03, 8'h00, "status is read only");
		host.wr(8'h20, 8'hFF);
		rchk(8'h20, 8'h00, "unmapped read");
		$display("test cfg done");
	endtask
	task automatic test_open();
		host.wr(8'h06, 8'h3B);
		open_det_pin = 6'h04;
		cyc(6);
		chk({11'h000, string_open_flag}, 12'h000, "open on disabled string");
		host.wr(8'h06, 8'h3F);
		cyc(6);
		open_det_pin = 6'h00;
		cyc(4);
		chk({11'h000, string_open_flag}, 12'h001, "open set");
		host.wr(8'h06, 8'h3B);
		cyc(3);
		chk({11'h000, string_open_flag}, 12'h001, "open held without read");
		rchk(8'h03, 8'h02, "status open");
		cyc(3);
		chk({11'h000, string_open_flag}, 12'h000, "open cleared");
		$display("test open done");
	endtask
	task automatic test_short();
		short_det_pin = 6'h01;
		cyc(6);
		short_det_pin = 6'h00;
		cyc(4);
		rchk(8'h03, 8'h01, "status short");
		host.wr(8'h06, 8'h01);
		cyc(3);
		chk({11'h000, string_short_flag}, 12'h001, "short held");
		host.wr(8'h06, 8'h00);
		cyc(3);
		chk({11'h000, string_short_flag}, 12'h000, "short cleared");
		short_det_pin = 6'h02;
		cyc(6);
		rchk(8'h03, 8'h01, "short again");
		cyc(3);
		chk({11'h000, string_short_flag}, 12'h001, "short kept while present");
		short_det_pin = 6'h00;
		cyc(4);
		rchk(8'h03, 8'h01, "short before clear");
		cyc(3);
		chk({11'h000, string_short_flag}, 12'h000, "short cleared again");
		$display("test short done");
	endtask
	// Waits for the applied code to reach the target, one step per period.
	task automatic ramp_run(input logic [7:0] per, input logic [11:0] tgt);
		logic [11:0] prev;
		int last;
		int steps;
		steps = 0;
		last = 0;
		host.wr(8'h04, per);
		host.wr(8'h07, {tgt[3:0], 4'h0});
		host.wr(8'h08, tgt[11:4]);
		prev = brightness_applied;
		for (int n = 0; n < 200 && brightness_applied !== tgt; n++) begin
			cyc(1);
			if (brightness_applied !== prev) begin
				chk(brightness_applied, (tgt > prev) ? prev + 12'h001 : prev - 12'h001,
					"one step");
				if (steps > 0) chk(12'(n - last), 12'(per * STEPS), "step spacing");
				steps++;
				last = n;
				prev = brightness_applied;
			end
		end
		chk(brightness_applied, tgt, "ramp reached");
	endtask
	task automatic test_ramp();
		host.wr(8'h07, 8'h50);
		cyc(2);
		chk(brightness_code, 12'h000, "low part staged");
		host.wr(8'h08, 8'h12);
		cyc(2);
		chk(brightness_code, 12'h125, "code committed");
		chk(brightness_applied, 12'h125, "no fading");
		ramp_run(8'h01, 12'h127);
		ramp_run(8'h02, 12'h124);
		$display("test ramp done");
	endtask
	task automatic test_pwm();
		pwm_in = 1'b1;
		cyc(4);
		chk({11'h000, pwm_level}, 12'h001, "pwm high");
		pwm_in = 1'b0;
		cyc(4);
		chk({11'h000, pwm_level}, 12'h000, "pwm low");
		$display("test pwm done");
	endtask
	task automatic wrap_up();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	initial begin
		repeat (12) @(posedge ref_clk);
		#1;
		rst = 1'b0;
		test_reset();
		test_cfg();
		test_open();
		test_short();
		test_ramp();
		test_pwm();
		wrap_up();
	end
endmodule
